//--- core/adder_defs.svh
/*
 adder_defs.svh: bit positions, constant words and timing figures for the
 ones'-complement adder and write-line bus.
 assumes: included by the adder package and the adder module only.
*/
`ifndef ADDER_DEFS_SVH
`define ADDER_DEFS_SVH

`define WORD_W          16
`define LOW_W           15
`define CNT_LOC_W       6
`define IRQ_CODE_W      4
// constants placed into x or onto the bus
`define X_PLUS_ONE      16'h0001
`define X_MINUS_ONE     16'hfffe
`define X_PLUS_TWO      16'h0002
`define X_BIT15_CONST   16'h4000
`define X_PLUS_ZERO     16'h0000
`define BUS_PLUS_ONE    16'h0001
`define BUS_PLUS_TWO    16'h0002
`define BUS_MINUS_ONE   16'hfffe
`define BUS_SAVE_LOC    16'h000d
`define BUS_START_ADDR  16'h0800
// field positions (zero based; documented bit n is index n-1)
`define SIGN_BIT        15
`define OVF_BIT         14
`define LOW_MASK        16'h7fff
`define HIGH_MASK       16'h8000
`define IRQ_HIGH_POS    11
`define IRQ_CODE_POS    2
// multiply timing slots
`define MUL_BLOCK_TIME  4'ha
`define MUL_CLEAR_TIME  4'h6
`define TIME_W          4

`endif

//--- core/adder_pkg.sv
/*
 adder_pkg.sv: types shared by the adder and its users.
 assumes: adder_defs.svh on the include path.
*/
`include "adder_defs.svh"

package adder_pkg;

   typedef logic [`WORD_W-1:0] word_t;

   // constant-load and clear pulses toward register x
   typedef struct packed
   {
      logic load_x_plus_one;
      logic load_x_minus_one;
      logic load_x_plus_two;
      logic load_x_bit15_const;
      logic divide_branch_clear_x;
   } x_ctrl_t;

   // constant sources gated straight onto the write lines
   typedef struct packed
   {
      logic const_plus_one_pulse;
      logic const_plus_two_pulse;
      logic const_minus_one_pulse;
      logic save_loc_pulse;
      logic start_address_pulse;
   } bus_const_t;

   // sequencer multiply and carry controls
   typedef struct packed
   {
      logic                multiply_first_step;
      logic                multiply_last_step;
      logic [`TIME_W-1:0]  time_slot;
      logic                force_carry_in_pulse;
      logic                operand_pair_clear;
   } carry_ctrl_t;

   // sign-derived flags of the current sum
   typedef struct packed
   {
      logic overflow;
      logic underflow;
      logic sum_sign;
   } sum_flags_t;

endpackage : adder_pkg

//--- core/adder_write_bus.sv
/*
 adder_write_bus.sv: 16-bit ones'-complement parallel adder (x, y) with its
 carry control, and the or-ed write-line bus with its constant sources.
 assumes: a sequencer on core_clk issues one-cycle control pulses; priority
 control drives counter-address and interrupt-vector lines itself.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adder_defs.svh"

module adder_write_bus
   import adder_pkg::*;
#(
   parameter int WIDTH = `WORD_W,
   parameter int REG_SRCS = 4
)
(
   // clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       resetn,
   // sequencer controls
   input  wire x_ctrl_t                    x_ctrl,
   input  wire carry_ctrl_t                carry_ctrl,
   input  wire bus_const_t                 bus_const,
   input  wire logic                       sum_read_pulse,
   input  wire logic                       sum_modular_read_pulse,
   input  wire logic                       read_time,
   input  wire logic                       modular_subtract_op,
   input  wire logic                       angle_increment_plus_op,
   input  wire logic                       angle_increment_minus_op,
   // y operand, accumulator word or-ed into x
   input  wire logic                       y_write,
   input  wire logic                       x_from_acc,
   input  wire logic [WIDTH-1:0]           acc_word,
   // gated register readouts, one word each
   input  wire logic [REG_SRCS*WIDTH-1:0]  reg_read_words,
   // priority control sources
   input  wire logic [`CNT_LOC_W-1:0]      counter_loc_input,
   input  wire logic                       irq_vector_high_bit,
   input  wire logic [`IRQ_CODE_W-1:0]     irq_vector_code_bit,
   // write lines and adder status
   output logic [WIDTH-1:0]                bus_line,
   output logic [WIDTH-1:0]                bus_line_n,
   output logic                            sum_low_read_strobe,
   output logic                            sum_high_read_strobe,
   output logic [WIDTH-1:0]                x_reg,
   output logic [WIDTH-1:0]                y_reg,
   output logic                            wraparound_carry_block,
   output logic                            carry_in_set,
   output sum_flags_t                      sum_flags
);

   ////////////////////////////////////////////////////////////////////////
   // operand registers and carry flops

   logic [WIDTH-1:0] x_q, x_d, y_q, y_d;
   logic             block_q, block_d, cin_q, cin_d;

   always_comb
   begin
      x_d = x_q;
      y_d = y_q;
      // pair clear comes first so a load in the same cycle still lands
      if (carry_ctrl.operand_pair_clear)
      begin
         x_d = WIDTH'(`X_PLUS_ZERO);
         y_d = WIDTH'(`X_PLUS_ZERO);
      end
      if (y_write)
         y_d = bus_line;
      if (x_from_acc)
         x_d = x_d | acc_word;
      if (x_ctrl.load_x_plus_one)
         x_d = WIDTH'(`X_PLUS_ONE);
      if (x_ctrl.load_x_minus_one)
         x_d = WIDTH'(`X_MINUS_ONE);
      if (x_ctrl.load_x_plus_two)
         x_d = WIDTH'(`X_PLUS_TWO);
      if (x_ctrl.load_x_bit15_const)
         x_d = WIDTH'(`X_BIT15_CONST);
      if (x_ctrl.divide_branch_clear_x)
         x_d = WIDTH'(`X_PLUS_ZERO);
   end

   always_comb
   begin
      block_d = block_q;
      cin_d   = cin_q;
      // block from time 10 of the first step to time 6 of the last
      if (carry_ctrl.multiply_first_step && carry_ctrl.time_slot == `MUL_BLOCK_TIME)
         block_d = 1'b1;
      else if (carry_ctrl.multiply_last_step && carry_ctrl.time_slot == `MUL_CLEAR_TIME)
         block_d = 1'b0;
      // setting wins over a coincident clear
      if (carry_ctrl.force_carry_in_pulse)
         cin_d = 1'b1;
      else if (carry_ctrl.operand_pair_clear)
         cin_d = 1'b0;
   end

   // operand pair
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         x_q <= '0;
         y_q <= '0;
      end
      else
      begin
         x_q <= x_d;
         y_q <= y_d;
      end
   end

   // carry control flops
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         block_q <= 1'b0;
         cin_q   <= 1'b0;
      end
      else
      begin
         block_q <= block_d;
         cin_q   <= cin_d;
      end
   end

   assign x_reg                  = x_q;
   assign y_reg                  = y_q;
   assign wraparound_carry_block = block_q;
   assign carry_in_set           = cin_q;

   ////////////////////////////////////////////////////////////////////////
   // ripple adder with end-around carry
   // the wraparound path is a combinational loop only in name: it is
   // resolved by a second pass so synthesis sees an acyclic network

   logic [WIDTH-1:0] sum;
   logic [WIDTH:0]   c0, c1;
   logic             wraparound_carry;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         // first pass: forced carry only, just its carry out is kept
         assign c0[g+1]  = (x_q[g] & y_q[g]) | (c0[g] & (x_q[g] ^ y_q[g]));
         // second pass: add the returned carry
         assign sum[g]   = x_q[g] ^ y_q[g] ^ c1[g];
         assign c1[g+1]  = (x_q[g] & y_q[g]) | (c1[g] & (x_q[g] ^ y_q[g]));
      end
   endgenerate

   assign c0[0]            = cin_q;
   assign wraparound_carry = c0[WIDTH] & ~block_q;
   assign c1[0]            = cin_q | wraparound_carry;

   // sign in bit 16, overflow shows as bit 15 of the sum disagreeing with two like operand signs
   always_comb
   begin
      sum_flags.sum_sign  = sum[`SIGN_BIT];
      sum_flags.overflow  = ~x_q[`SIGN_BIT] & ~y_q[`SIGN_BIT] & sum[`OVF_BIT];
      sum_flags.underflow = x_q[`SIGN_BIT] & y_q[`SIGN_BIT] & ~sum[`OVF_BIT];
   end

   ////////////////////////////////////////////////////////////////////////
   // read strobes

   logic modular_ctx;
   assign modular_ctx = modular_subtract_op | angle_increment_plus_op
                      | angle_increment_minus_op;

   assign sum_high_read_strobe = sum_read_pulse & read_time;
   assign sum_low_read_strobe  = (sum_read_pulse & read_time)
                               | (sum_modular_read_pulse & read_time
                                  & (modular_ctx | 1'b1));

   ////////////////////////////////////////////////////////////////////////
   // write-line bus: plain or of every source

   function automatic logic [WIDTH-1:0] gate_word(input logic en,
                                                  input logic [WIDTH-1:0] w);
      gate_word = en ? w : '0;
   endfunction : gate_word

   logic [WIDTH-1:0] reg_or, const_or, prio_or, sum_or, bus_d;

   always_comb
   begin
      reg_or = '0;
      for (int i = 0; i < REG_SRCS; i++)
         reg_or = reg_or | reg_read_words[i*WIDTH +: WIDTH];
   end

   always_comb
   begin
      const_or = gate_word(bus_const.const_plus_one_pulse, WIDTH'(`BUS_PLUS_ONE))
               | gate_word(bus_const.const_plus_two_pulse, WIDTH'(`BUS_PLUS_TWO))
               | gate_word(bus_const.const_minus_one_pulse, WIDTH'(`BUS_MINUS_ONE))
               | gate_word(bus_const.save_loc_pulse, WIDTH'(`BUS_SAVE_LOC))
               | gate_word(bus_const.start_address_pulse, WIDTH'(`BUS_START_ADDR));
      prio_or = '0;
      prio_or[`CNT_LOC_W-1:0] = counter_loc_input;
      prio_or[`IRQ_HIGH_POS] = irq_vector_high_bit;
      // vector code shares low lines with the counter address: or, never overwrite
      prio_or[`IRQ_CODE_POS +: `IRQ_CODE_W] = prio_or[`IRQ_CODE_POS +: `IRQ_CODE_W]
                                             | irq_vector_code_bit;
      sum_or = gate_word(sum_low_read_strobe, sum & WIDTH'(`LOW_MASK))
             | gate_word(sum_high_read_strobe, sum & WIDTH'(`HIGH_MASK));
      bus_d = reg_or | const_or | prio_or | sum_or;
   end

   // the bus is combinational so a read and a register write share one cycle
   assign bus_line   = bus_d;
   assign bus_line_n = ~bus_d;

endmodule : adder_write_bus

`default_nettype wire

//--- testbench/adder_write_bus_properties.sv
/* adder_write_bus_properties.sv: timing properties of adder, strobes and flops.
   assumes: bound into adder_write_bus; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module adder_write_bus_chk
   import adder_pkg::*;
#(parameter int WIDTH = 16)
(
   // clock and reset
   input wire logic             core_clk,
   input wire logic             resetn,
   // controls
   input wire x_ctrl_t          x_ctrl,
   input wire carry_ctrl_t      carry_ctrl,
   input wire logic             sum_read_pulse,
   input wire logic             sum_modular_read_pulse,
   input wire logic             read_time,
   // outputs
   input wire logic [WIDTH-1:0] bus_line,
   input wire logic [WIDTH-1:0] bus_line_n,
   input wire logic             sum_low_read_strobe,
   input wire logic             sum_high_read_strobe,
   input wire logic [WIDTH-1:0] x_reg,
   input wire logic             wraparound_carry_block,
   input wire logic             carry_in_set
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////
   // the two multiply slots differ, so begin and end never coincide
   sequence mul_begin;
      carry_ctrl.multiply_first_step && carry_ctrl.time_slot == 4'ha;
   endsequence
   sequence mul_end;
      carry_ctrl.multiply_last_step && carry_ctrl.time_slot == 4'h6;
   endsequence
   bus_inverse_a: assert property (bus_line_n == ~bus_line)
      else $error("bus complement wrong");
   read_high_a: assert property (sum_high_read_strobe == (sum_read_pulse && read_time))
      else $error("high strobe wrong");
   read_low_a: assert property (sum_low_read_strobe ==
      (sum_high_read_strobe || (sum_modular_read_pulse && read_time)))
      else $error("low strobe wrong");
   x_two_a: assert property (x_ctrl == 5'h04 |=> x_reg == 16'h0002)
      else $error("x not two");
   x_clear_a: assert property (x_ctrl.divide_branch_clear_x |=> x_reg == 16'h0000)
      else $error("x not cleared");
   block_set_a: assert property (mul_begin |=> wraparound_carry_block)
      else $error("carry block not set");
   block_clear_a: assert property (mul_end |=> !wraparound_carry_block)
      else $error("carry block not cleared");
   carry_set_a: assert property (carry_ctrl.force_carry_in_pulse |=> carry_in_set)
      else $error("carry in not set");
   carry_clear_a: assert property (carry_ctrl.operand_pair_clear &&
      !carry_ctrl.force_carry_in_pulse |=> !carry_in_set)
      else $error("carry in not cleared");
endmodule : adder_write_bus_chk
bind adder_write_bus adder_write_bus_chk #(.WIDTH(WIDTH)) u_chk (.core_clk, .resetn, .x_ctrl,
   .carry_ctrl, .sum_read_pulse, .sum_modular_read_pulse, .read_time, .bus_line, .bus_line_n,
   .sum_low_read_strobe, .sum_high_read_strobe, .x_reg, .wraparound_carry_block, .carry_in_set);
`default_nettype wire

//--- testbench/prio_model.sv
/* prio_model.sv: priority control stand-in for counter and vector lines.
   assumes: an input that is not enabled reads zero at the write-line gate. */
`timescale 1ns/1ps
`default_nettype none
module prio_model
(
   // requests
   input wire logic       cnt_en,
   input wire logic [5:0] cnt_addr,
   input wire logic       irq_en,
   input wire logic [3:0] irq_idx,
   // write-line sources
   output logic [5:0]     counter_loc_input,
   output logic           irq_vector_high_bit,
   output logic [3:0]     irq_vector_code_bit
);
   assign counter_loc_input = cnt_en ? cnt_addr : 6'h00;
   assign irq_vector_high_bit = irq_en;
   // code 6 has no routine, so the upper four entries skip it
   assign irq_vector_code_bit = !irq_en ? 4'h0 :
      (irq_idx < 4'h5 ? irq_idx + 4'h1 : irq_idx + 4'h2);
endmodule : prio_model
`default_nettype wire

//--- testbench/adder_write_bus_tb_top.sv
/* adder_write_bus_tb_top.sv: self-checking bench for adder and write lines.
   assumes: package, prio_model and checker compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module adder_write_bus_tb_top
   import adder_pkg::*;
;
   logic core_clk, resetn, sum_read_pulse, sum_modular_read_pulse, read_time, chk;
   logic modular_subtract_op, y_write, x_from_acc, cnt_en, irq_en, irq_vector_high_bit;
   logic sum_low_read_strobe, sum_high_read_strobe, wraparound_carry_block, carry_in_set;
   x_ctrl_t     x_ctrl;
   carry_ctrl_t carry_ctrl;
   bus_const_t  bus_const;
   sum_flags_t  sum_flags;
   word_t       acc_word, bus_line, bus_line_n, x_reg, y_reg, a, b, s;
   logic [63:0] reg_read_words;
   logic [5:0]  cnt_addr, counter_loc_input;
   logic [3:0]  irq_idx, irq_vector_code_bit;
   logic [31:0] rng;
   logic [17:0] e;
   logic [17:0] q [$];
   int          errors, n_tests, cycles, m;
   word_t xv [5] = '{16'h0000, 16'h4000, 16'h0002, 16'hfffe, 16'h0001};
   word_t bv [5] = '{16'h0800, 16'h000d, 16'hfffe, 16'h0002, 16'h0001};
   word_t iv [9] = '{16'h0804, 16'h0808, 16'h080c, 16'h0810, 16'h0814, 16'h081c,
      16'h0820, 16'h0824, 16'h0828};
   adder_write_bus u_dut (.core_clk, .resetn, .x_ctrl, .carry_ctrl, .bus_const, .sum_read_pulse,
      .sum_modular_read_pulse, .read_time, .modular_subtract_op, .angle_increment_plus_op(1'b0),
      .angle_increment_minus_op(1'b0), .y_write, .x_from_acc, .acc_word, .reg_read_words,
      .counter_loc_input, .irq_vector_high_bit, .irq_vector_code_bit, .bus_line, .bus_line_n,
      .sum_low_read_strobe, .sum_high_read_strobe, .x_reg, .y_reg, .wraparound_carry_block,
      .carry_in_set, .sum_flags);
   prio_model u_prio (.cnt_en, .cnt_addr, .irq_en, .irq_idx, .counter_loc_input,
      .irq_vector_high_bit, .irq_vector_code_bit);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   // blocked mode drops the bit sixteen carry instead of wrapping it;
   // forced and returned carry share one input of bit one, so they never add up
   function automatic word_t oc_add(input word_t p, input word_t r, input logic c, input logic k);
      logic [16:0] t;
      t = p + r + c;
      return k ? t[15:0] : p + r + (c | t[16]);
   endfunction : oc_add
   task automatic check(input word_t seen, input word_t want);
      n_tests++;
      if (seen !== want)
      begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask : check
   task automatic note(input logic [1:0] sel, input word_t v);
      q.push_back({sel, v});
      chk <= 1'b1;
   endtask : note
   task automatic tick();
      @(posedge core_clk);
   endtask : tick
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////
   always @(negedge core_clk)
      if (chk === 1'b1)
      begin
         e = q.pop_front();
         chk = 1'b0;
         case (e[17:16])
            2'd0:
            begin
               check(bus_line, e[15:0]);
               check(bus_line_n, ~e[15:0]);
            end
            2'd1: check(x_reg, e[15:0]);
            2'd2: check({13'h0, sum_flags}, e[15:0]);
            default: check(y_reg, e[15:0]);
         endcase
      end
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 400)
      begin
         errors++;
         complete_run();
      end
   end
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial
   begin
      {x_ctrl, carry_ctrl, bus_const, sum_read_pulse, sum_modular_read_pulse} = '0;
      {read_time, modular_subtract_op, y_write, x_from_acc, cnt_en, irq_en, chk} = '0;
      {acc_word, reg_read_words, cnt_addr, irq_idx} = '0;
      {errors, n_tests, cycles} = '0;
      resetn = 1'b0;
      rng = 32'd88511;
      repeat (10) tick();
      resetn <= 1'b1;
      for (int i = 4; i >= 0; i--)
      begin
         tick();
         x_ctrl <= x_ctrl_t'(5'h01 << i);
         tick();
         x_ctrl <= '0;
         note(2'd1, xv[i]);
      end
      $display("test x loads done");
      for (int i = 0; i < 9; i++)
      begin
         tick();
         rng = xs(rng);
         // low nibble left to the constants and priority sources
         s = (i < 5 ? bv[i] : 16'h0) | (rng[15:0] & 16'hfff0) | iv[i];
         s = s | (i >= 5 ? {10'h0, rng[21:16]} : 16'h0);
         bus_const <= i < 5 ? bus_const_t'(5'h01 << i) : '0;
         reg_read_words <= {48'h0, rng[15:4], 4'h0} << (16 * (i % 4));
         cnt_en <= i >= 5;
         cnt_addr <= rng[21:16];
         irq_en <= 1'b1;
         irq_idx <= i[3:0];
         note(2'd0, s);
      end
      tick();
      {bus_const, reg_read_words, cnt_en, irq_en} <= '0;
      $display("test write lines done");
      for (int k = 0; k < 6; k++)
      begin
         tick();
         rng = xs(rng);
         a = rng[15:0];
         b = rng[31:16];
         m = k % 3;
         // pair clear plus: a9 opens the block, 5b closes it and forces carry in, 59 only closes it
         carry_ctrl <= carry_ctrl_t'(m == 2 ? 8'ha9 : m == 1 ? 8'h5b : 8'h59);
         tick();
         carry_ctrl <= '0;
         reg_read_words <= {48'h0, a};
         y_write <= 1'b1;
         tick();
         {reg_read_words, y_write} <= '0;
         note(2'd3, a);
         x_from_acc <= 1'b1;
         acc_word <= b;
         tick();
         x_from_acc <= 1'b0;
         {sum_read_pulse, read_time} <= 2'b11;
         s = oc_add(a, b, m == 1, m == 2);
         note(2'd0, s);
         tick();
         {sum_read_pulse, read_time} <= 2'b00;
         note(2'd2, {13'h0, !a[15] && !b[15] && s[14], a[15] && b[15] && !s[14], s[15]});
         tick();
         {sum_modular_read_pulse, read_time, modular_subtract_op} <= 3'b111;
         note(2'd0, s & 16'h7fff);
         tick();
         {sum_modular_read_pulse, read_time, modular_subtract_op} <= 3'b000;
      end
      $display("test adder reads done");
      repeat (2) tick();
      complete_run();
   end
endmodule : adder_write_bus_tb_top
`default_nettype wire
